//--- rtl/bkd_pkg.sv
// What this block does
// - Entry key: batch label, quantity, stop lit, flashing.
// - First digit clears display, shows digit only.
// - Further digits enter right, shift left.
// - Second entry press stores, shows set label.
// - Clear removes last digit, shifts right.
// - Clearing only digit restores stored quantity.
// - During run, entry key only shows quantity flashing.
// - Run lights run LED, totals up or down.
// - Stop pauses; run resumes; second stop aborts.
// - Pause LED flashes; abort lights stop steadily.
// - Manual reset reloads total at batch end.
// - Auto reset: run press reloads and restarts.
// - Rate key toggles rate view, restores LEDs.
// - Any state change drops rate view.
// - Holding accumulate key shows accumulated total.
// - No key ever clears accumulated total.
// - Quantity above configured limit is refused.
// - Rate-totaliser mode ignores run, stop, entry.
// - Rate-totaliser: rate key toggles rate and total.
// - Default view is batch total, reloaded per batch.
// - Display and entry buffer hold six digits.
package bkd_pkg;

  // ----------------------------------------------------------------
  // Sizes and timing
  // ----------------------------------------------------------------
  localparam int DIGITS = 6;
  localparam int QTY_W = 4 * DIGITS;
  localparam int CLK_HZ = 40000000;
  localparam int LABEL_TIME_MS = 1000;
  localparam int BLINK_TIME_MS = 250;
  localparam int LABEL_CYCLES = CLK_HZ / 1000 * LABEL_TIME_MS;
  localparam int BLINK_CYCLES = CLK_HZ / 1000 * BLINK_TIME_MS;
  localparam int TIMER_W = 26;

  // ----------------------------------------------------------------
  // Register map (byte addresses) and fields
  // ----------------------------------------------------------------
  localparam logic [3:0] ADDR_CFG = 4'h0;
  localparam logic [3:0] ADDR_LIMIT = 4'h4;
  localparam logic [3:0] ADDR_QTY = 4'h8;
  localparam logic [3:0] ADDR_STATUS = 4'hc;
  localparam int CFG_COUNT_DOWN = 0;
  localparam int CFG_AUTO_RESET = 1;
  localparam int CFG_RATE_TOT = 2;
  localparam int CFG_LIMIT_EN = 3;
  localparam int CFG_DP_LSB = 4;
  localparam int CFG_W = 7;
  localparam logic [CFG_W-1:0] CFG_RESET = 7'h00;
  localparam logic [QTY_W-1:0] QTY_RESET = 24'h000000;
  localparam logic [QTY_W-1:0] LIMIT_RESET = 24'h999999;

  // ----------------------------------------------------------------
  // Key bit positions; digit keys occupy bits 0 to 9, digit 0 is accumulate
  // ----------------------------------------------------------------
  localparam int K_ACCUM = 0;
  localparam int K_ENTRY = 10;
  localparam int K_RUN = 11;
  localparam int K_STOP = 12;
  localparam int K_RESET = 13;
  localparam int K_RATE = 14;
  localparam int K_CLEAR = 15;
  localparam int KEYS = 16;

  // ----------------------------------------------------------------
  // LED bits and display sources
  // ----------------------------------------------------------------
  localparam int L_RUN = 0;
  localparam int L_STOP = 1;
  localparam int L_PAUSE = 2;
  localparam int L_RATE = 3;
  localparam logic [2:0] DSP_TOTAL = 3'h0;
  localparam logic [2:0] DSP_RATE = 3'h1;
  localparam logic [2:0] DSP_ACCUM = 3'h2;
  localparam logic [2:0] DSP_QTY = 3'h3;
  localparam logic [2:0] DSP_LBL_BATCH = 3'h4;
  localparam logic [2:0] DSP_LBL_SET = 3'h5;

  typedef enum logic [2:0] {
    MD_IDLE = 3'b000,
    MD_RUN = 3'b001,
    MD_PAUSE = 3'b010,
    MD_STOP = 3'b011,
    MD_DONE = 3'b100
  } bkd_mode_t;

  typedef enum logic [2:0] {
    UI_NORM = 3'b000,
    UI_LBL_BATCH = 3'b001,
    UI_EDIT = 3'b010,
    UI_LBL_SET = 3'b011,
    UI_PEEK = 3'b100
  } bkd_ui_t;

endpackage

//--- rtl/bkd_top.sv
// Design decisions made here: the Avalon-MM interface to the registers and the address map.
`timescale 1ns/1ps
module bkd_top #(
  parameter int LABEL_CYCLES = bkd_pkg::LABEL_CYCLES,
  parameter int BLINK_CYCLES = bkd_pkg::BLINK_CYCLES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Avalon-MM register slave
  input wire logic [3:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  // Operator keys, high while pressed, asynchronous
  input wire logic [9:0] key_digit,
  input wire logic key_entry,
  input wire logic key_run,
  input wire logic key_stop,
  input wire logic key_reset,
  input wire logic key_rate,
  input wire logic key_clear,
  // Totaliser
  input wire logic batch_done,
  output logic total_run,
  output logic total_reload,
  output logic total_count_down,
  // Non-volatile storage
  output logic nv_write,
  output logic [bkd_pkg::QTY_W-1:0] nv_qty,
  // Indicators and display
  output logic led_run,
  output logic led_stop,
  output logic led_pause,
  output logic led_rate,
  output logic [2:0] disp_sel,
  output logic [bkd_pkg::QTY_W-1:0] disp_value,
  output logic [2:0] disp_len,
  output logic disp_flash,
  output logic [2:0] disp_dp
);
  import bkd_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [KEYS-1:0] s1;
    logic [KEYS-1:0] s2;
    logic [KEYS-1:0] s3;
    bkd_mode_t mode;
    bkd_ui_t ui;
    logic [TIMER_W-1:0] timer;
    logic [TIMER_W-1:0] blink_cnt;
    logic blink;
    logic [QTY_W-1:0] buf_q;
    logic [2:0] cnt;
    logic [QTY_W-1:0] stored;
    logic [CFG_W-1:0] cfg;
    logic [QTY_W-1:0] limit;
    logic rate_view;
    logic [3:0] led;
    logic [2:0] dsel;
    logic [QTY_W-1:0] dval;
    logic [2:0] dlen;
    logic dflash;
    logic trun;
    logic treload;
    logic nvw;
    logic wait_q;
    logic [31:0] rdata;
  } bkd_state_t;

  bkd_state_t q;
  bkd_state_t next_q;

  logic [KEYS-1:0] rise;
  logic rt;
  logic any_digit;
  logic [3:0] digit;
  logic over_limit;
  bkd_mode_t nm;
  logic [3:0] base_led;

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  // Keys are only ever read after the second synchroniser stage.
  always_comb begin
    next_q = q;
    next_q.s1 = {key_clear, key_rate, key_reset, key_stop, key_run, key_entry, key_digit};
    next_q.s2 = q.s1;
    next_q.s3 = q.s2;
    rise = q.s2 & ~q.s3;
    rt = q.cfg[CFG_RATE_TOT];
    any_digit = |rise[9:0];
    digit = 4'h0;
    for (int i = 9; i >= 0; i--) begin
      if (rise[i]) begin
        digit = 4'(i);
      end
    end
    // BCD digits compare in the same order as their values.
    over_limit = q.cfg[CFG_LIMIT_EN] && (q.buf_q > q.limit);
    next_q.treload = 1'b0;
    next_q.nvw = 1'b0;

    // Pause blink base and label timer.
    if (q.blink_cnt >= TIMER_W'(BLINK_CYCLES - 1)) begin
      next_q.blink_cnt = '0;
      next_q.blink = ~q.blink;
    end else begin
      next_q.blink_cnt = q.blink_cnt + 1'b1;
    end
    if (q.timer != '0) begin
      next_q.timer = q.timer - 1'b1;
    end

    // Bus slave: one wait state, write lands on the edge waitrequest is low.
    next_q.wait_q = !((read || write) && q.wait_q);
    if (read && q.wait_q) begin
      case (address)
        ADDR_CFG: next_q.rdata = {25'h0, q.cfg};
        ADDR_LIMIT: next_q.rdata = {8'h00, q.limit};
        ADDR_QTY: next_q.rdata = {8'h00, q.stored};
        ADDR_STATUS: next_q.rdata = {20'h0, 3'h0, q.rate_view, 1'b0, q.ui, 1'b0, q.mode};
        default: next_q.rdata = 32'h00000000;
      endcase
    end
    if (write && !q.wait_q) begin
      case (address)
        ADDR_CFG: next_q.cfg = writedata[CFG_W-1:0];
        ADDR_LIMIT: next_q.limit = writedata[QTY_W-1:0];
        ADDR_QTY: next_q.stored = writedata[QTY_W-1:0];
        default: next_q.cfg = q.cfg;
      endcase
    end

    // Front-panel editing sequence.
    case (q.ui)
      UI_NORM: begin
        if (rise[K_ENTRY] && !rt) begin
          if (q.mode == MD_RUN) begin
            next_q.ui = UI_PEEK;
          end else begin
            next_q.ui = UI_LBL_BATCH;
            next_q.timer = TIMER_W'(LABEL_CYCLES);
            next_q.rate_view = 1'b0;
          end
        end
      end
      UI_LBL_BATCH: begin
        if (q.timer == TIMER_W'(1)) begin
          next_q.ui = UI_EDIT;
          next_q.buf_q = q.stored;
          next_q.cnt = 3'h0;
        end
      end
      UI_EDIT: begin
        if (any_digit) begin
          if (q.cnt == 3'h0) begin
            next_q.buf_q = {20'h00000, digit};
            next_q.cnt = 3'h1;
          end else if (q.cnt < 3'(DIGITS)) begin
            // Past six digits further keys are dropped; the display cannot show them.
            next_q.buf_q = {q.buf_q[QTY_W-5:0], digit};
            next_q.cnt = q.cnt + 3'h1;
          end
        end else if (rise[K_CLEAR]) begin
          if (q.cnt <= 3'h1) begin
            next_q.buf_q = q.stored;
            next_q.cnt = 3'h0;
          end else begin
            next_q.buf_q = {4'h0, q.buf_q[QTY_W-1:4]};
            next_q.cnt = q.cnt - 3'h1;
          end
        end else if (rise[K_ENTRY]) begin
          if (over_limit) begin
            next_q.buf_q = q.stored;
            next_q.cnt = 3'h0;
          end else begin
            next_q.stored = q.buf_q;
            next_q.nvw = 1'b1;
            next_q.ui = UI_LBL_SET;
            next_q.timer = TIMER_W'(LABEL_CYCLES);
          end
        end
      end
      UI_LBL_SET: begin
        if (q.timer == TIMER_W'(1)) begin
          next_q.ui = UI_NORM;
        end
      end
      UI_PEEK: begin
        if (!q.s2[K_ENTRY]) begin
          next_q.ui = UI_NORM;
        end
      end
      default: next_q.ui = UI_NORM;
    endcase

    // Batch states; operation keys act only outside editing.
    nm = q.mode;
    if (!rt && q.ui == UI_NORM) begin
      case (q.mode)
        MD_IDLE: begin
          if (rise[K_RUN]) begin
            nm = MD_RUN;
            next_q.treload = 1'b1;
          end
        end
        MD_RUN: begin
          if (rise[K_STOP]) begin
            nm = MD_PAUSE;
          end
        end
        MD_PAUSE: begin
          if (rise[K_RUN]) begin
            nm = MD_RUN;
          end else if (rise[K_STOP]) begin
            nm = MD_STOP;
          end
        end
        MD_STOP, MD_DONE: begin
          if (rise[K_RUN] && q.cfg[CFG_AUTO_RESET]) begin
            nm = MD_RUN;
            next_q.treload = 1'b1;
          end else if (rise[K_RESET]) begin
            nm = MD_IDLE;
            next_q.treload = 1'b1;
          end
        end
        default: nm = MD_IDLE;
      endcase
    end
    if (q.mode == MD_RUN && batch_done) begin
      nm = MD_DONE;
    end
    next_q.mode = nm;

    // Rate overlay; a state change always returns to the batch total.
    if (nm != q.mode) begin
      next_q.rate_view = 1'b0;
    end else if (rise[K_RATE] && q.ui == UI_NORM) begin
      next_q.rate_view = ~q.rate_view;
    end

    // Indicators follow the batch state, so leaving the rate view restores them.
    base_led = 4'h0;
    if (!rt) begin
      base_led[L_RUN] = (nm == MD_RUN);
      base_led[L_STOP] = (nm == MD_STOP) || (next_q.ui == UI_LBL_BATCH) ||
        (next_q.ui == UI_EDIT);
      base_led[L_PAUSE] = (nm == MD_PAUSE) && q.blink;
    end
    next_q.led = base_led;
    if (next_q.rate_view) begin
      next_q.led = '0;
      next_q.led[L_RATE] = 1'b1;
    end

    // Display source, highest priority first.
    next_q.dval = q.stored;
    next_q.dlen = 3'(DIGITS);
    next_q.dflash = 1'b0;
    case (next_q.ui)
      UI_LBL_BATCH: begin
        next_q.dsel = DSP_LBL_BATCH;
        next_q.dflash = 1'b1;
      end
      UI_LBL_SET: next_q.dsel = DSP_LBL_SET;
      UI_EDIT: begin
        next_q.dsel = DSP_QTY;
        next_q.dval = next_q.buf_q;
        next_q.dlen = (next_q.cnt == 3'h0) ? 3'(DIGITS) : next_q.cnt;
        next_q.dflash = 1'b1;
      end
      UI_PEEK: begin
        next_q.dsel = DSP_QTY;
        next_q.dflash = 1'b1;
      end
      default: begin
        if (q.s2[K_ACCUM]) begin
          next_q.dsel = DSP_ACCUM;
        end else if (next_q.rate_view) begin
          next_q.dsel = DSP_RATE;
        end else begin
          next_q.dsel = DSP_TOTAL;
        end
      end
    endcase

    // In rate-totaliser mode the totaliser always runs; nothing here clears the accumulated total.
    next_q.trun = rt || (nm == MD_RUN);
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      q <= '0;
      q.mode <= MD_IDLE;
      q.ui <= UI_NORM;
      q.cfg <= CFG_RESET;
      q.stored <= QTY_RESET;
      q.limit <= LIMIT_RESET;
      q.dsel <= DSP_TOTAL;
      q.dlen <= 3'(DIGITS);
      q.wait_q <= 1'b1;
    end else begin
      q <= next_q;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign readdata = q.rdata;
  assign waitrequest = q.wait_q;
  assign total_run = q.trun;
  assign total_reload = q.treload;
  assign total_count_down = q.cfg[CFG_COUNT_DOWN];
  assign nv_write = q.nvw;
  assign nv_qty = q.stored;
  assign led_run = q.led[L_RUN];
  assign led_stop = q.led[L_STOP];
  assign led_pause = q.led[L_PAUSE];
  assign led_rate = q.led[L_RATE];
  assign disp_sel = q.dsel;
  assign disp_value = q.dval;
  assign disp_len = q.dlen;
  assign disp_flash = q.dflash;
  assign disp_dp = q.cfg[CFG_DP_LSB +: 3];

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_label_to_edit: assert property (@(posedge clk) disable iff (reset)
    (q.ui == UI_LBL_BATCH && q.timer == TIMER_W'(1)) |=> (q.ui == UI_EDIT && q.buf_q == $past(q.stored)
    && disp_flash && led_stop)) else $error("label did not lead into editing");
  a_first_digit: assert property (@(posedge clk) disable iff (reset)
    (q.ui == UI_EDIT && q.cnt == 3'h0 && any_digit) |=> (q.cnt == 3'h1 && q.buf_q[QTY_W-1:4] == '0))
    else $error("first digit did not clear the buffer");
  a_digit_shift: assert property (@(posedge clk) disable iff (reset)
    (q.ui == UI_EDIT && q.cnt != 3'h0 && q.cnt < 3'h6 && any_digit)
    |=> (q.buf_q[QTY_W-1:4] == $past(q.buf_q[QTY_W-5:0]) && q.cnt == $past(q.cnt) + 3'h1))
    else $error("digit was not shifted in");
  a_commit_store: assert property (@(posedge clk) disable iff (reset)
    (q.ui == UI_EDIT && !any_digit && !rise[K_CLEAR] && rise[K_ENTRY] && !over_limit)
    |=> (nv_write && nv_qty == $past(q.buf_q) && disp_sel == DSP_LBL_SET) ##1 !nv_write)
    else $error("commit did not store the quantity");
  a_clear_shift: assert property (@(posedge clk) disable iff (reset)
    (q.ui == UI_EDIT && !any_digit && rise[K_CLEAR] && q.cnt > 3'h1)
    |=> (q.buf_q == {4'h0, $past(q.buf_q[QTY_W-1:4])} && q.cnt == $past(q.cnt) - 3'h1))
    else $error("clear did not shift right");
  a_clear_restore: assert property (@(posedge clk) disable iff (reset)
    (q.ui == UI_EDIT && !any_digit && rise[K_CLEAR] && q.cnt == 3'h1)
    |=> (q.cnt == 3'h0 && disp_value == q.stored)) else $error("last clear did not restore");
  a_peek_run: assert property (@(posedge clk) disable iff (reset)
    (q.ui == UI_NORM && q.mode == MD_RUN && rise[K_ENTRY] && !rt)
    |=> (q.ui == UI_PEEK && q.mode != MD_IDLE)) else $error("run entry press did not peek");
  a_run_start: assert property (@(posedge clk) disable iff (reset)
    (q.ui == UI_NORM && q.mode == MD_IDLE && rise[K_RUN] && !rt)
    |=> (total_reload && total_run && led_run == !q.rate_view)) else $error("run did not start");
  a_pause_abort: assert property (@(posedge clk) disable iff (reset)
    (q.ui == UI_NORM && q.mode == MD_PAUSE && rise[K_STOP] && !rise[K_RUN] && !rt)
    |=> (q.mode == MD_STOP && led_stop && !total_run)) else $error("second stop did not abort");
  a_limit_refuse: assert property (@(posedge clk) disable iff (reset)
    (q.ui == UI_EDIT && !any_digit && !rise[K_CLEAR] && rise[K_ENTRY] && over_limit)
    |=> (!nv_write && q.ui == UI_EDIT && q.stored == $past(q.stored))) else $error("limit not enforced");
  a_rate_drop: assert property (@(posedge clk) disable iff (reset)
    (q.mode != $past(q.mode)) |-> !q.rate_view) else $error("rate view survived a state change");
  a_rt_ignore: assert property (@(posedge clk) disable iff (reset)
    (rt && q.ui == UI_NORM) |=> (q.ui == UI_NORM && !total_reload && !nv_write))
    else $error("rate totaliser acted on a batch key");

  c_commit: cover property (@(posedge clk) disable iff (reset) q.ui == UI_EDIT ##1 nv_write);
  c_abort: cover property (@(posedge clk) disable iff (reset) q.mode == MD_PAUSE ##1 q.mode == MD_STOP);
  c_rate_view: cover property (@(posedge clk) disable iff (reset) $rose(q.rate_view));
  c_done: cover property (@(posedge clk) disable iff (reset) q.mode == MD_RUN ##1 q.mode == MD_DONE);

endmodule

//--- tb/bkd_panel.sv
`timescale 1ns/1ps
// ------------------------------------------------------------------
// Operator panel: presses and holds keys the way a person would
// ------------------------------------------------------------------
module bkd_panel (
  // Clock
  input wire logic clk,
  // Keys, high while pressed
  output logic [9:0] key_digit,
  output logic key_entry,
  output logic key_run,
  output logic key_stop,
  output logic key_reset,
  output logic key_rate,
  output logic key_clear
);
  import bkd_pkg::*;
  logic [KEYS-1:0] keys = '0;

  // One key vector fans out to the separate key pins.
  assign key_digit = keys[9:0];
  assign key_entry = keys[K_ENTRY];
  assign key_run = keys[K_RUN];
  assign key_stop = keys[K_STOP];
  assign key_reset = keys[K_RESET];
  assign key_rate = keys[K_RATE];
  assign key_clear = keys[K_CLEAR];

  // A key goes down or up only just after a rising edge.
  task hold(input int k);
    @(posedge clk);
    keys[k] <= 1'b1;
  endtask

  task let_go(input int k);
    @(posedge clk);
    keys[k] <= 1'b0;
  endtask

  // Held three edges, so the two-flop synchroniser cannot miss it.
  task press(input int k);
    hold(k);
    repeat (3) @(posedge clk);
    keys[k] <= 1'b0;
  endtask
endmodule

//--- tb/test_batch_keypad_display_control.sv
`timescale 1ns/1ps
module test_batch_keypad_display_control;
  import bkd_pkg::*;
  // ------------------------------------------------------------------
  // Harness
  // ------------------------------------------------------------------
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic [3:0] address = 4'h0;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [31:0] writedata = 32'h0;
  logic [31:0] readdata;
  logic waitrequest;
  logic [9:0] key_digit;
  logic key_entry, key_run, key_stop, key_reset, key_rate, key_clear;
  logic batch_done = 1'b0;
  logic total_run, total_reload, total_count_down, nv_write;
  logic [QTY_W-1:0] nv_qty, disp_value;
  logic led_run, led_stop, led_pause, led_rate, disp_flash;
  logic [2:0] disp_sel, disp_len, disp_dp;
  logic [31:0] rd;
  int checks = 0;
  int bad_count = 0;
  int nv_n = 0;
  int rl_n = 0;

  // Short label and blink counts keep the run brief.
  bkd_top #(.LABEL_CYCLES(8), .BLINK_CYCLES(4)) dut (
    .clk, .reset, .address, .read, .write, .writedata, .readdata, .waitrequest,
    .key_digit, .key_entry, .key_run, .key_stop, .key_reset, .key_rate, .key_clear,
    .batch_done, .total_run, .total_reload, .total_count_down, .nv_write, .nv_qty,
    .led_run, .led_stop, .led_pause, .led_rate, .disp_sel, .disp_value, .disp_len,
    .disp_flash, .disp_dp
  );

  bkd_panel panel (
    .clk, .key_digit, .key_entry, .key_run, .key_stop, .key_reset, .key_rate, .key_clear
  );

  // Clock generator.
  initial begin
    forever #12.5 clk = ~clk;
  end

  // One-cycle pulses are tallied, since a test may look a few cycles late.
  always @(posedge clk) begin
    if (nv_write === 1'b1) nv_n++;
    if (total_reload === 1'b1) rl_n++;
  end

  // ------------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------------
  task wrap_up;
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Samples just after an edge, once that edge's updates have landed.
  task step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // Avalon master: holds the request until waitrequest is sampled low.
  task bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    address <= a;
    writedata <= d;
    read <= ~wr;
    write <= wr;
    do begin
      @(posedge clk);
      n++;
    end while (waitrequest !== 1'b0);
    rd = readdata;
    // One wait state: the answer is sampled on the second edge after the request rises.
    chk("bus wait", 32'h2, 32'(n));
    read <= 1'b0;
    write <= 1'b0;
  endtask

  task st(input logic [2:0] m);
    bus(1'b0, ADDR_STATUS, 32'h0);
    chk("mode", 32'(m), 32'(rd[2:0]));
  endtask

  // A press, then time for the synchroniser and the reaction.
  task kp(input int k);
    panel.press(k);
    step(3);
  endtask

  // ------------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------------
  task t_regs;
    bus(1'b0, ADDR_CFG, 32'h0);
    chk("cfg reset", 32'h0, rd);
    bus(1'b0, ADDR_LIMIT, 32'h0);
    chk("limit reset", 32'h999999, rd);
    bus(1'b0, 4'h2, 32'h0);
    chk("unmapped", 32'h0, rd);
    bus(1'b1, ADDR_QTY, 32'h4205);
    bus(1'b0, ADDR_QTY, 32'h0);
    chk("qty", 32'h4205, rd);
    $display("t_regs done");
  endtask

  task t_limit;
    int n;
    bus(1'b1, ADDR_LIMIT, 32'h9999);
    bus(1'b1, ADDR_CFG, 32'h38);
    panel.press(K_ENTRY);
    step(13);
    for (int i = 0; i < 5; i++) kp(9);
    n = nv_n;
    kp(K_ENTRY);
    chk("nv refused", 0, nv_n - n);
    chk("value reverted", 32'h4205, disp_value);
    chk("still edit", DSP_QTY, disp_sel);
    kp(K_ENTRY);
    chk("nv in limit", 1, nv_n - n);
    step(10);
    $display("t_limit done");
  endtask

  task t_entry;
    int n;
    bus(1'b1, ADDR_CFG, 32'h30);
    panel.press(K_ENTRY);
    step(2);
    chk("label", DSP_LBL_BATCH, disp_sel);
    chk("flash", 1, disp_flash);
    chk("stop led", 1, led_stop);
    step(10);
    chk("sel qty", DSP_QTY, disp_sel);
    chk("stored", 32'h4205, disp_value);
    kp(1);
    chk("len", 1, disp_len);
    chk("first", 32'h1, disp_value);
    chk("dp", 3, disp_dp);
    kp(3);
    kp(0);
    kp(4);
    chk("shifted", 32'h1304, disp_value);
    chk("len4", 4, disp_len);
    kp(K_CLEAR);
    chk("clear1", 32'h130, disp_value);
    chk("len3", 3, disp_len);
    kp(K_CLEAR);
    kp(K_CLEAR);
    chk("clear3", 32'h1, disp_value);
    kp(K_CLEAR);
    chk("restored", 32'h4205, disp_value);
    for (int i = 1; i < 8; i++) kp(i);
    chk("six digits", 32'h123456, disp_value);
    n = nv_n;
    kp(K_ENTRY);
    chk("set label", DSP_LBL_SET, disp_sel);
    chk("nv pulse", 1, nv_n - n);
    chk("nv qty", 32'h123456, nv_qty);
    step(10);
    chk("back", DSP_TOTAL, disp_sel);
    bus(1'b0, ADDR_QTY, 32'h0);
    chk("qty reg", 32'h123456, rd);
    $display("t_entry done");
  endtask

  task t_run;
    int n;
    logic p, tg;
    n = rl_n;
    kp(K_RUN);
    chk("run led", 1, led_run);
    chk("total run", 1, total_run);
    chk("count up", 0, total_count_down);
    chk("reload", 1, rl_n - n);
    st(3'h1);
    kp(K_STOP);
    st(3'h2);
    chk("paused total", 0, total_run);
    p = led_pause;
    tg = 1'b0;
    repeat (10) begin
      step(1);
      if (led_pause !== p) tg = 1'b1;
    end
    chk("blink", 1, tg);
    kp(K_RUN);
    st(3'h1);
    chk("pause off", 0, led_pause);
    kp(K_STOP);
    kp(K_STOP);
    st(3'h3);
    step(9);
    chk("stop steady", 1, led_stop);
    chk("pause off2", 0, led_pause);
    n = rl_n;
    kp(K_RESET);
    chk("reset reload", 1, rl_n - n);
    $display("t_run done");
  endtask

  task t_view;
    int n;
    kp(K_RUN);
    kp(K_RATE);
    chk("rate sel", DSP_RATE, disp_sel);
    chk("rate led", 1, led_rate);
    kp(K_RATE);
    chk("total sel", DSP_TOTAL, disp_sel);
    chk("rate led off", 0, led_rate);
    chk("run kept", 1, led_run);
    kp(K_RATE);
    kp(K_STOP);
    chk("stop drops rate", DSP_TOTAL, disp_sel);
    chk("rate led drop", 0, led_rate);
    kp(K_RUN);
    kp(K_RATE);
    panel.hold(K_ACCUM);
    step(6);
    chk("accum", DSP_ACCUM, disp_sel);
    panel.let_go(K_ACCUM);
    step(6);
    chk("rate again", DSP_RATE, disp_sel);
    chk("rate led again", 1, led_rate);
    kp(K_RATE);
    panel.hold(K_ENTRY);
    step(6);
    chk("peek", DSP_QTY, disp_sel);
    chk("peek flash", 1, disp_flash);
    chk("peek value", 32'h123456, disp_value);
    panel.let_go(K_ENTRY);
    step(6);
    chk("peek gone", DSP_TOTAL, disp_sel);
    kp(K_RATE);
    @(posedge clk);
    batch_done <= 1'b1;
    step(3);
    chk("done drops rate", DSP_TOTAL, disp_sel);
    chk("done total", 0, total_run);
    st(3'h4);
    @(posedge clk);
    batch_done <= 1'b0;
    kp(K_RUN);
    st(3'h4);
    n = rl_n;
    kp(K_RESET);
    chk("done reload", 1, rl_n - n);
    $display("t_view done");
  endtask

  task t_auto;
    int n;
    bus(1'b1, ADDR_CFG, 32'h33);
    kp(K_RUN);
    @(posedge clk);
    batch_done <= 1'b1;
    step(3);
    @(posedge clk);
    batch_done <= 1'b0;
    n = rl_n;
    kp(K_RUN);
    chk("auto reload", 1, rl_n - n);
    st(3'h1);
    chk("count down", 1, total_count_down);
    kp(K_STOP);
    kp(K_STOP);
    $display("t_auto done");
  endtask

  task t_rtot;
    logic [31:0] s;
    bus(1'b1, ADDR_CFG, 32'h4);
    bus(1'b0, ADDR_STATUS, 32'h0);
    s = rd;
    kp(K_RUN);
    kp(K_STOP);
    kp(K_ENTRY);
    step(2);
    chk("no label", DSP_TOTAL, disp_sel);
    bus(1'b0, ADDR_STATUS, 32'h0);
    chk("state kept", s, rd);
    kp(K_RATE);
    chk("rt rate led", 1, led_rate);
    chk("rt rate sel", DSP_RATE, disp_sel);
    kp(K_RATE);
    chk("rt led off", 0, led_rate);
    chk("rt total sel", DSP_TOTAL, disp_sel);
    $display("t_rtot done");
  endtask

  // Main sequence.
  initial begin
    repeat (6) @(posedge clk);
    reset <= 1'b0;
    t_regs();
    t_limit();
    t_entry();
    t_run();
    t_view();
    t_auto();
    t_rtot();
    wrap_up();
  end

  // Watchdog: well beyond the few hundred cycles the tests need.
  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    wrap_up();
  end
endmodule
